/* File: uss_pkg.sv */
package uss_pkg;

  // ==========================================================
  // Clock and master clock timing
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned MCLK_HALF_NS  = 200;
  localparam int unsigned MCLK_HALF_CYC = (MCLK_HALF_NS * CLK_MHZ) / 1000;
  localparam logic [7:0]  MCLK_HALF_CNT = 8'(MCLK_HALF_CYC);

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_TXCS = 8'h00;
  localparam logic [7:0] OFS_RXCS = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_TXD  = 8'h0C;
  localparam logic [7:0] OFS_RXD  = 8'h10;
  localparam logic [7:0] OFS_FLAG = 8'h14;

  // ==========================================================
  // Field positions
  localparam int TX_CLOCK_SOURCE_SELECT = 7;
  localparam int TX_NINE = 6;
  localparam int TX_EN   = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_BRK  = 3;
  localparam int TX_EMPT = 1;
  localparam int TX_D9   = 0;
  localparam int RX_PEN  = 7;
  localparam int RX_NINE = 6;
  localparam int RX_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RX_OVERRUN_ERROR = 1;
  localparam int RX_D9   = 0;
  localparam int RT_OVF  = 7;
  localparam int RT_IDLE = 6;
  localparam int RT_POL  = 4;
  localparam int RT_WIDE = 3;
  localparam int RT_WAKE = 1;
  localparam int RT_ABD  = 0;
  localparam int FL_GIE  = 7;
  localparam int FL_PERIPHERAL_INTERRUPT_ENABLE = 6;
  localparam int FL_RXP  = 5;
  localparam int FL_TXF  = 4;
  localparam int FL_RXIE = 1;
  localparam int FL_TX_INTERRUPT_ENABLE = 0;

  // ==========================================================
  // Write masks and reset values
  localparam logic [7:0] TXCS_WMASK = 8'hFD;
  localparam logic [7:0] RXCS_WMASK = 8'hF8;
  localparam logic [7:0] RATE_WMASK = 8'h1B;
  localparam logic [7:0] FLAG_WMASK = 8'hC3;
  localparam logic [7:0] REG_RST    = 8'h00;
  localparam logic [3:0] BITS_8     = 4'h8;
  localparam logic [3:0] BITS_9     = 4'h9;

  typedef enum logic [2:0] {
    MD_OFF, MD_ASYNC, MD_SYNC_IDLE, MD_SYNC_TX, MD_SYNC_RX
  } uss_mode_t;

endpackage : uss_pkg

/* File: uss_pin_sync.sv */
module uss_pin_sync (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  import uss_pkg::*;

  logic meta;
  logic stage;
  logic prev;

  // ==========================================================
  // Two-stage synchroniser, then an edge detector on stage two
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta  <= 1'b0;
      stage <= 1'b0;
      prev  <= 1'b0;
    end
    else
    begin
      meta  <= pin_in;
      stage <= meta;
      prev  <= stage;
    end
  end

  assign level_out = stage;
  assign rise_out  = stage & ~prev;
  assign fall_out  = ~stage & prev;

endmodule : uss_pin_sync

/* File: uss_sync_slave.sv */
// How it works
// [R1] Slave reception keeps continuous receive on; single receive is ignored.
// [R2] Full character in sleep goes to the receive buffer; enabled it wakes.
// [R3] Only slave mode shifts during sleep; master clock halts while sleeping.
// [R4] Slave shift registers run only from the external clock pin.
// [R5] Completed word during sleep sets receive pending, which wakes.
// [R6] Wake resumes after sleep; global enable also requests the vector.
// [R7] Sleep transmit: next buffer byte loads, buffer free sets; write clears.
// [R8] External master drives the clock and handles the data pin.
// [R9] Clock source bit: 1 master with internal clock, 0 slave; sync only.
// [R10] Transmit bits: nine-bit frames, transmit enable, synchronous select.
// [R11] Break request only in async; hardware clears it on completion.
// [R12] Shift-register-empty status reads 1 when empty, resets to 1.
// [R13] In sync mode a receive enable beats transmit enable.
// [R14] Clearing port enable holds the serial port in reset.
// [R15] Master single receive clears after one character; continuous wins.
// [R16] Address detect applies only to nine-bit async reception.
// [R17] Framing and overrun are read-only; clearing continuous clears overrun once single receive is off or data is read.
// [R18] Polarity sets sync clock idle level, or inverted async idle.
// [R19] Wide rate bit picks a 16-bit rate generator, else 8-bit.
// [R20] Async wake: falling data edge raises event, rising edge clears enable.
// [R21] Auto-baud enable clears when done; overflow bit reports overflow.
// [R22] Receiver idle flag reflects async receiver; don't-care in sync mode.
// [R23] Data changes on leading edge, sampled on trailing, one bit per clock.
// [R24] Two-deep receive buffer; third character sets overrun and blocks.
module uss_sync_slave (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        sleep_in,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe_out,
  input  wire logic        serial_data_pin_in,
  output logic             serial_data_pin_out,
  output logic             serial_data_pin_oe_out,
  input  wire logic        async_break_done_in,
  input  wire logic        autobaud_done_in,
  input  wire logic        autobaud_ovf_in,
  input  wire logic        async_rx_busy_in,
  output logic             wake_out,
  output logic             vector_request_out,
  output logic             wide_rate_select_out,
  output logic             async_tx_idle_out
);
  import uss_pkg::*;

  function automatic logic [3:0] frame_bits(input logic nine);
    frame_bits = nine ? BITS_9 : BITS_8;
  endfunction : frame_bits

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == OFS_TXCS) || (a == OFS_RXCS) || (a == OFS_RATE) ||
               (a == OFS_TXD) || (a == OFS_RXD) || (a == OFS_FLAG);
  endfunction : addr_hit

  logic [7:0] txcs;
  logic [7:0] rxcs;
  logic [7:0] ratec;
  logic [7:0] flagc;
  logic [7:0] rd_mux;
  uss_mode_t  mode;
  logic       sync_md;
  logic       master;
  logic       pen;
  logic       pol;
  logic       rx_en;
  logic       tx_mode;
  logic       ck_lvl;
  logic       ck_rise;
  logic       ck_fall;
  logic       dt_lvl;
  logic       dt_rise;
  logic       dt_fall;
  logic       lead;
  logic       trail;
  logic       mclk;
  logic       tick;
  logic       run;
  logic [7:0] dcnt;
  logic [8:0] rx_shift_register;
  logic [8:0] rx_next;
  logic [8:0] rx_word;
  logic [3:0] rcnt;
  logic [3:0] rx_bits;
  logic [3:0] tx_bits;
  logic       rx_done;
  logic       push;
  logic       ovr_set;
  logic       pop;
  logic       overrun_error;
  logic [8:0] fifo [2];
  logic       rd_ptr;
  logic [1:0] fcnt;
  logic [8:0] txbuf;
  logic       txbuf_valid;
  logic [8:0] tx_shift_register;
  logic       tsr_full;
  logic       t_first;
  logic [3:0] tcnt;
  logic       tx_load;
  logic       tx_end;
  logic       setup;
  logic       access;
  logic       wr;
  logic       tdata_wr;
  logic       rd_pop_ok;
  logic       wake_seen;
  logic       irq;

  // ==========================================================
  // Pin synchronisers
  uss_pin_sync u_ck_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    (serial_clock_pin_in),
    .level_out (ck_lvl),
    .rise_out  (ck_rise),
    .fall_out  (ck_fall)
  );

  uss_pin_sync u_dt_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    (serial_data_pin_in),
    .level_out (dt_lvl),
    .rise_out  (dt_rise),
    .fall_out  (dt_fall)
  );

  // ==========================================================
  // Mode decode
  assign sync_md = txcs[TX_SYNC];                          // R10
  assign master  = sync_md & txcs[TX_CLOCK_SOURCE_SELECT];                // R9
  assign pen     = rxcs[RX_PEN];                           // R14
  assign pol     = ratec[RT_POL];

  always_comb
  begin
    if (!pen)
      mode = MD_OFF;
    else if (!sync_md)
      mode = MD_ASYNC;
    else if (rxcs[RX_CONTINUOUS_RECEIVE_ENABLE] || (master && rxcs[RX_SINGLE_RECEIVE_ENABLE]))  // R1 R15
      mode = MD_SYNC_RX;                                   // R13
    else if (txcs[TX_EN])
      mode = MD_SYNC_TX;
    else
      mode = MD_SYNC_IDLE;
  end

  always_comb
  begin
    rx_en   = 1'b0;
    tx_mode = 1'b0;
    case (mode)
      MD_SYNC_RX: rx_en   = 1'b1;
      MD_SYNC_TX: tx_mode = 1'b1;
      default:    ;
    endcase
  end

  assign rx_bits = frame_bits(rxcs[RX_NINE]);
  assign tx_bits = frame_bits(txcs[TX_NINE]);

  // ==========================================================
  // Master clock: halts in sleep, so only slave keeps shifting
  assign run  = master && pen && !sleep_in &&                 // R3
                ((rx_en && !overrun_error) || (tx_mode && tsr_full));
  assign tick = (dcnt == MCLK_HALF_CNT - 8'h01);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dcnt <= 8'h00;
      mclk <= 1'b0;
    end
    else if (!master || !pen)
    begin
      dcnt <= 8'h00;
      mclk <= pol;                                         // R18
    end
    else if (tick)
    begin
      dcnt <= 8'h00;
      if (run || mclk != pol)
        mclk <= ~mclk;
    end
    else
      dcnt <= dcnt + 8'h01;
  end

  // Leading edge leaves the idle level, trailing edge returns to it
  always_comb
  begin
    if (master)
    begin
      lead  = tick && run && (mclk == pol);
      trail = tick && (mclk != pol);
    end
    else
    begin
      lead  = pol ? ck_fall : ck_rise;                      // R4 R8
      trail = pol ? ck_rise : ck_fall;                      // R23
    end
  end

  assign serial_clock_pin_out    = mclk;
  assign serial_clock_pin_oe_out = master && pen;          // R9

  // ==========================================================
  // Receive shifter, sampled on trailing edge
  assign rx_next = {dt_lvl, rx_shift_register[8:1]};
  assign rx_word = rxcs[RX_NINE] ? rx_next : {1'b0, rx_next[8:1]};
  assign rx_done = rx_en && !overrun_error && trail &&
                   (rcnt == rx_bits - 4'h1);
  assign push    = rx_done && (fcnt != 2'h2);
  assign ovr_set = rx_done && (fcnt == 2'h2);             // R24

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_shift_register  <= 9'h000;
      rcnt <= 4'h0;
    end
    else if (!rx_en || overrun_error)
      rcnt <= 4'h0;                                        // R24
    else if (trail)
    begin
      rx_shift_register  <= rx_next;                                     // R23
      rcnt <= rx_done ? 4'h0 : rcnt + 4'h1;
    end
  end

  // ==========================================================
  // Two-entry receive buffer
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_ptr <= 1'b0;
      fcnt   <= 2'h0;
    end
    else if (!pen)
    begin
      rd_ptr <= 1'b0;
      fcnt   <= 2'h0;                                      // R14
    end
    else
    begin
      if (pop)
        rd_ptr <= ~rd_ptr;
      fcnt <= fcnt + {1'b0, push} - {1'b0, pop};           // R2 R5
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
      fifo[rd_ptr ^ fcnt[0]] <= rx_word;
  end

  // Overrun set beats a clear in the same cycle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      overrun_error <= 1'b0;
    else if (!pen)
      overrun_error <= 1'b0;
    else if (ovr_set)
      overrun_error <= 1'b1;                                        // R24
    else if (!rxcs[RX_CONTINUOUS_RECEIVE_ENABLE] && (!rxcs[RX_SINGLE_RECEIVE_ENABLE] || pop))
      overrun_error <= 1'b0;                                        // R17
  end

  // ==========================================================
  // Transmit buffer and shifter
  assign tdata_wr = wr && (paddr_in == OFS_TXD);
  assign tx_load  = tx_mode && txbuf_valid && !tsr_full;   // R7
  assign tx_end   = tx_mode && tsr_full && trail &&
                    (tcnt == tx_bits - 4'h1);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      txbuf       <= 9'h000;
      txbuf_valid <= 1'b0;
    end
    else if (!pen)
      txbuf_valid <= 1'b0;
    else if (tdata_wr)
    begin
      txbuf       <= {txcs[TX_D9], pwdata_in[7:0]};
      txbuf_valid <= 1'b1;                                 // R7
    end
    else if (tx_load)
      txbuf_valid <= 1'b0;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_shift_register      <= 9'h1FF;
      tsr_full <= 1'b0;
      t_first  <= 1'b0;
      tcnt     <= 4'h0;
    end
    else if (!tx_mode)
      tsr_full <= 1'b0;                                    // R13 R14
    else if (tx_load)
    begin
      tx_shift_register      <= txcs[TX_NINE] ? txbuf : {1'b1, txbuf[7:0]};
      tsr_full <= 1'b1;                                    // R12
      t_first  <= 1'b1;
      tcnt     <= 4'h0;
    end
    else if (tsr_full && lead)
    begin
      t_first <= 1'b0;
      if (!t_first)
        tx_shift_register <= {1'b1, tx_shift_register[8:1]};                           // R23
    end
    else if (tsr_full && trail)
    begin
      tcnt <= tcnt + 4'h1;
      if (tx_end)
        tsr_full <= 1'b0;                                  // R12
    end
  end

  assign serial_data_pin_out    = tx_shift_register[0];
  assign serial_data_pin_oe_out = tx_mode;                 // R13

  // ==========================================================
  // Control registers
  assign setup  = psel_in && !penable_in;
  assign access = psel_in && penable_in;
  assign wr     = access && pwrite_in;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      txcs <= REG_RST;
    else if (wr && paddr_in == OFS_TXCS)
      txcs <= pwdata_in[7:0] & TXCS_WMASK;
    else if (!sync_md && async_break_done_in)
      txcs[TX_BRK] <= 1'b0;                                // R11
  end

  // Software write wins over the hardware single-receive clear
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rxcs <= REG_RST;
    else if (wr && paddr_in == OFS_RXCS)
      rxcs <= pwdata_in[7:0] & RXCS_WMASK;                 // R16
    else if (rx_done && master)
      rxcs[RX_SINGLE_RECEIVE_ENABLE] <= 1'b0;                               // R15
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ratec <= REG_RST;
    else if (wr && paddr_in == OFS_RATE)
      ratec <= pwdata_in[7:0] & RATE_WMASK;
    else
    begin
      if (!sync_md && wake_seen && dt_rise)
        ratec[RT_WAKE] <= 1'b0;                            // R20
      if (!sync_md && autobaud_done_in)
        ratec[RT_ABD] <= 1'b0;                             // R21
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      flagc <= REG_RST;
    else if (wr && paddr_in == OFS_FLAG)
      flagc <= pwdata_in[7:0] & FLAG_WMASK;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      wake_seen <= 1'b0;
    else if (sync_md || !pen || !ratec[RT_WAKE])
      wake_seen <= 1'b0;
    else if (dt_fall)
      wake_seen <= 1'b1;                                   // R20
  end

  assign wide_rate_select_out = ratec[RT_WIDE];            // R19
  assign async_tx_idle_out    = ~pol;                      // R18

  // ==========================================================
  // Read mux; receive data read pops the buffer
  always_comb
  begin
    rd_mux = 8'h00;
    case (paddr_in)
      OFS_TXCS:
      begin
        rd_mux          = txcs;
        rd_mux[TX_EMPT] = ~tsr_full;                       // R12
      end
      OFS_RXCS:
      begin
        rd_mux          = rxcs;
        rd_mux[RX_OVERRUN_ERROR] = overrun_error;                            // R17
        rd_mux[RX_D9]   = fifo[rd_ptr][8];
      end
      OFS_RATE:
      begin
        rd_mux          = ratec;
        rd_mux[RT_OVF]  = !sync_md && autobaud_ovf_in;     // R21
        rd_mux[RT_IDLE] = sync_md || !async_rx_busy_in;    // R22
      end
      OFS_RXD:  rd_mux = fifo[rd_ptr][7:0];
      OFS_FLAG:
      begin
        rd_mux          = flagc;
        rd_mux[FL_RXP]  = (fcnt != 2'h0);                  // R5
        rd_mux[FL_TXF]  = ~txbuf_valid;                    // R7
      end
      default:  rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
      rd_pop_ok   <= 1'b0;
    end
    else if (setup)
    begin
      prdata_out  <= {24'h00_0000, rd_mux};
      pslverr_out <= !addr_hit(paddr_in);
      rd_pop_ok   <= !pwrite_in && (paddr_in == OFS_RXD) &&
                     (fcnt != 2'h0);
    end
  end

  assign pready_out = 1'b1;
  assign pop        = access && rd_pop_ok;

  // ==========================================================
  // Wake and vector requests
  assign irq = flagc[FL_PERIPHERAL_INTERRUPT_ENABLE] &&
               (((fcnt != 2'h0) && flagc[FL_RXIE]) ||
                (!txbuf_valid && flagc[FL_TX_INTERRUPT_ENABLE]) || wake_seen);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wake_out           <= 1'b0;
      vector_request_out <= 1'b0;
    end
    else
    begin
      wake_out           <= sleep_in && irq;               // R2 R5
      vector_request_out <= irq && flagc[FL_GIE];          // R6
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  AST_SLAVE_NO_CLK: assert property ( // R9
    (sync_md && !txcs[TX_CLOCK_SOURCE_SELECT]) |-> !serial_clock_pin_oe_out)
    else $error("clock pin driven in slave mode");
  AST_RX_OVER_TX: assert property ( // R13
    rx_en |-> !serial_data_pin_oe_out)
    else $error("data pin driven while receiving");
  AST_PORT_OFF: assert property ( // R14
    !pen |=> (fcnt == 2'h0) && !tsr_full && !overrun_error)
    else $error("port disabled but state not reset");
  AST_RX_PENDING: assert property ( // R5
    push |=> (fcnt != 2'h0) ##1 (fcnt != 2'h0) || $past(pop))
    else $error("completed word not buffered");
  AST_OVERRUN: assert property ( // R24
    ovr_set |=> overrun_error && $stable(fifo[0]) && $stable(fifo[1]) &&
      (fcnt == ($past(pop) ? 2'h1 : 2'h2)))
    else $error("overrun lost or altered buffered data");
  AST_TX_FREE: assert property ( // R7
    (tx_load && !tdata_wr) |=> !txbuf_valid && tsr_full)
    else $error("buffer free not set after shifter load");
  AST_EMPTY_END: assert property ( // R12
    tx_end |=> !tsr_full)
    else $error("shift register empty not reported");
  AST_SINGLE_RECEIVE_ENABLE_CLR: assert property ( // R15
    (rx_done && master && !(wr && paddr_in == OFS_RXCS))
      |=> !rxcs[RX_SINGLE_RECEIVE_ENABLE])
    else $error("single receive not cleared");
  AST_WAKE: assert property ( // R2
    (sleep_in && irq) |=> wake_out)
    else $error("no wake on pending event");
  AST_VECTOR: assert property ( // R6
    (irq && flagc[FL_GIE]) |=> vector_request_out)
    else $error("vector not requested");
  AST_SLEEP_HALT: assert property ( // R3
    (master && sleep_in && mclk == pol) |=> (mclk == pol))
    else $error("master clock ran during sleep");

  COV_RX_DONE:  cover property (push);
  COV_TX_LOAD:  cover property (tx_load ##[1:400] tx_end);
  COV_OVERRUN:  cover property (ovr_set);
  COV_WAKE:     cover property (sleep_in && wake_out);

endmodule : uss_sync_slave

/* File: uss_master_model.sv */
module uss_master_model (
  input  wire logic clk_in,
  input  wire logic data_in,
  output logic      sck_out,
  output logic      sdo_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy;

  initial
  begin
    busy = 1'b0;
    sck_out = 1'b0;
    sdo_out = 1'b0;
  end

  // ==========================================================
  // Released data line toggles so a stale bit never passes
  always @(posedge clk_in)
  begin
    if (!busy)
      sdo_out <= ~sdo_out;
  end

  // ==========================================================
  // One frame: data changes on the rising (leading) edge,
  // sampled on the falling (trailing) edge; clock idles low
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    busy = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_in);
      sck_out <= 1'b1;
      sdo_out <= tx[i];
      repeat (8) @(posedge clk_in);
      sck_out <= 1'b0;
      rx[i] = data_in;
      repeat (8) @(posedge clk_in);
    end
    busy = 1'b0;
  endtask : xfer
endmodule : uss_master_model

/* File: uss_sync_slave_tb_top.sv */
module uss_sync_slave_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import uss_pkg::*;
  logic        clk_in, rst_in, psel, pen, pwr, slp, perr;
  logic [7:0]  paddr, rx;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, sck_o, sck_oe, sd_o, sd_oe, m_sck, m_sd;
  logic        wake, vec, wide, txidle;
  logic        brk_done, abd_done, abd_ovf, rx_busy;
  int          miscompares, cmp_count;
  wire logic   sck_pin = sck_oe ? sck_o : m_sck;
  wire logic   sd_pin = sd_oe ? sd_o : m_sd;

  uss_sync_slave dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .sleep_in(slp), .serial_clock_pin_in(sck_pin),
    .serial_clock_pin_out(sck_o), .serial_clock_pin_oe_out(sck_oe),
    .serial_data_pin_in(sd_pin), .serial_data_pin_out(sd_o),
    .serial_data_pin_oe_out(sd_oe), .async_break_done_in(brk_done),
    .autobaud_done_in(abd_done), .autobaud_ovf_in(abd_ovf),
    .async_rx_busy_in(rx_busy), .wake_out(wake), .vector_request_out(vec),
    .wide_rate_select_out(wide), .async_tx_idle_out(txidle));

  uss_master_model m (.clk_in(clk_in), .data_in(sd_pin),
    .sck_out(m_sck), .sdo_out(m_sd));

  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // Idle cycle after each transfer lets registered outputs land
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      miscompares++;
      conclude();
    end
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_in);
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rdc

  task automatic wait_wake();
    int n;
    n = 0;
    while (wake !== 1'b1 && n < 200)
    begin
      @(posedge clk_in);
      n++;
    end
    chk(32'(wake), 32'h1);
    if (wake !== 1'b1)
      conclude();
  endtask : wait_wake

  // ==========================================================
  // Stimulus
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial
  begin
    rst_in = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slp = 1'b0;
    {brk_done, abd_done, abd_ovf, rx_busy} = 4'h0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    rdc(OFS_TXCS, 32'h2);
    rdc(OFS_RATE, 32'h40);
    apb(1'b1, OFS_RATE, 32'h18);
    chk(32'(wide), 32'h1);
    chk(32'(txidle), 32'h0);
    apb(1'b1, OFS_RATE, 32'h0);
    chk(32'(txidle), 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(perr), 32'h1);
    apb(1'b1, OFS_RXCS, 32'h80);
    // Async hooks: break and auto-baud clears, toggling line clears wake
    apb(1'b1, OFS_TXCS, 32'h08);
    apb(1'b1, OFS_RATE, 32'h03);
    {brk_done, abd_done, abd_ovf, rx_busy} <= 4'hF;
    @(posedge clk_in);
    {brk_done, abd_done} <= 2'h0;
    rdc(OFS_TXCS, 32'h02);
    rdc(OFS_RATE, 32'h80);
    {abd_ovf, rx_busy} <= 2'h0;
    apb(1'b1, OFS_TXCS, 32'hB0);
    chk(32'(sck_oe), 32'h1);
    apb(1'b1, OFS_RXCS, 32'h0);
    chk(32'(sck_oe), 32'h0);
    apb(1'b1, OFS_TXCS, 32'h10);
    apb(1'b1, OFS_RXCS, 32'h90);
    apb(1'b1, OFS_FLAG, 32'h42);
    slp <= 1'b1;
    m.xfer(8'hA5, rx);
    chk(32'(sck_oe), 32'h0);
    wait_wake();
    chk(32'(vec), 32'h0);
    apb(1'b1, OFS_FLAG, 32'hC2);
    @(posedge clk_in);
    chk(32'(vec), 32'h1);
    apb(1'b0, OFS_FLAG, 32'h0);
    chk(32'(q[5]), 32'h1);
    slp <= 1'b0;
    rdc(OFS_RXD, 32'hA5);
    // Third whole character must be dropped
    for (int i = 1; i < 4; i++)
      m.xfer(8'(8'h11 * i), rx);
    repeat (8) @(posedge clk_in);
    rdc(OFS_RXCS, 32'h92);
    rdc(OFS_RXD, 32'h11);
    rdc(OFS_RXD, 32'h22);
    apb(1'b1, OFS_RXCS, 32'h80);
    rdc(OFS_RXCS, 32'h80);
    apb(1'b1, OFS_TXCS, 32'h30);
    apb(1'b1, OFS_FLAG, 32'h41);
    apb(1'b1, OFS_TXD, 32'h5A);
    apb(1'b1, OFS_TXD, 32'hC3);
    rdc(OFS_TXCS, 32'h30);
    apb(1'b0, OFS_FLAG, 32'h0);
    chk(32'(q[4]), 32'h0);
    slp <= 1'b1;
    chk(32'(sd_oe), 32'h1);
    m.xfer(8'h00, rx);
    chk(32'(rx), 32'h5A);
    wait_wake();
    apb(1'b1, OFS_TXD, 32'h7E);
    apb(1'b0, OFS_FLAG, 32'h0);
    chk(32'(q[4]), 32'h0);
    m.xfer(8'h00, rx);
    chk(32'(rx), 32'hC3);
    apb(1'b1, OFS_RXCS, 32'h90);
    chk(32'(sd_oe), 32'h0);
    slp <= 1'b0;
    // Master single receive: clock frozen in sleep, one character after
    apb(1'b1, OFS_RXCS, 32'h80);
    apb(1'b1, OFS_TXCS, 32'h90);
    slp <= 1'b1;
    apb(1'b1, OFS_RXCS, 32'hA0);
    repeat (60) @(posedge clk_in);
    chk(32'(sck_o), 32'h0);
    slp <= 1'b0;
    repeat (400) @(posedge clk_in);
    rdc(OFS_RXCS, 32'h80);
    conclude();
  end
endmodule : uss_sync_slave_tb_top
